// [hdl/strobe_timing_defines.svh]
// Field positions, widths and timing constants for the memory strobe sequencer
`ifndef STROBE_TIMING_DEFINES_SVH
`define STROBE_TIMING_DEFINES_SVH
`define FIELD_W          3
`define RSU_LSB          1
`define RPW_LSB          4
`define WSU_LSB          0
`define WPW_LSB          3
`define WHT_LO_LSB       6
`define WHT_HI_BIT       0
`define CTRL_LOW_RESET   8'h00
`define CTRL_HIGH_RESET  8'h00
`define BUS_PERIOD_NS    4
`define BUS_DIV_DEFAULT  2
`endif

// [hdl/strobe_timing_pkg.sv]
// Types for the memory strobe sequencer
package strobe_timing_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_TAIL  = 3'b100
  } seq_state_t;
endpackage : strobe_timing_pkg

// [hdl/async_memory_strobe_timing.sv]
// Strobe sequencer for an external byte-wide asynchronous memory
`timescale 1ns/1ps
`include "strobe_timing_defines.svh"

module async_memory_strobe_timing #(
  parameter int ADDR_W  = 16,
  parameter int BUS_DIV = `BUS_DIV_DEFAULT
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [7:0]        strobe_ctrl_low_byte_i,
  input  wire logic [7:0]        strobe_ctrl_high_byte_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic              req_fabric_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [7:0]        req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rd_valid_o,
  output logic [7:0]             rd_data_o,
  output logic                   bus_clk_o,
  output logic                   mem_ce_n_o,
  output logic                   mem_oe_n_o,
  output logic                   mem_we_n_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  input  wire logic [7:0]        mem_data_i,
  output logic [7:0]             mem_data_o,
  output logic                   mem_data_oe_n_o
);
  localparam int CW = $clog2(BUS_DIV) + 1;

  // Field extraction, each 3 bits wide covering 0..7
  logic [`FIELD_W-1:0] read_setup_cycles, read_pulse_cycles, write_setup_cycles, write_pulse_cycles, write_hold_cycles;
  assign read_setup_cycles = strobe_ctrl_high_byte_i[`RSU_LSB +: `FIELD_W];
  assign read_pulse_cycles = strobe_ctrl_high_byte_i[`RPW_LSB +: `FIELD_W];
  assign write_setup_cycles = strobe_ctrl_low_byte_i[`WSU_LSB +: `FIELD_W];
  assign write_pulse_cycles = strobe_ctrl_low_byte_i[`WPW_LSB +: `FIELD_W];
  assign write_hold_cycles = {strobe_ctrl_high_byte_i[`WHT_HI_BIT],
                strobe_ctrl_low_byte_i[`WHT_LO_LSB +: 2]};

  // Bus clock divider: rise and fall enables, one system cycle each
  logic [CW-1:0] div_reg, div_next;
  logic          bclk_reg, bclk_next;
  logic          rise_en, fall_en;

  always_comb begin
    div_next  = div_reg;
    bclk_next = bclk_reg;
    rise_en   = 1'b0;
    fall_en   = 1'b0;
    if (div_reg == CW'(BUS_DIV - 1)) begin
      div_next  = '0;
      bclk_next = ~bclk_reg;
      rise_en   = ~bclk_reg;
      fall_en   = bclk_reg;
    end else begin
      div_next = div_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_reg  <= '0;
      bclk_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      bclk_reg <= bclk_next;
    end
  end

  // Sequencer
  strobe_timing_pkg::seq_state_t state_reg, state_next;
  logic [`FIELD_W-1:0] cnt_reg, cnt_next;
  logic                wr_reg, wr_next;
  logic [`FIELD_W-1:0] pw_reg, pw_next;
  logic [`FIELD_W-1:0] ht_reg, ht_next;
  logic                ce_n_reg, ce_n_next;
  logic                oe_n_reg, oe_n_next;
  logic                we_n_reg, we_n_next;
  logic                doe_n_reg, doe_n_next;
  logic [ADDR_W-1:0]   addr_reg, addr_next;
  logic [7:0]          wdata_reg, wdata_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic                rvalid_reg, rvalid_next;

  // Fabric-selector accesses never enter the sequencer
  assign req_ready_o = (state_reg == strobe_timing_pkg::ST_IDLE) && rise_en && !req_fabric_i;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    wr_next     = wr_reg;
    pw_next     = pw_reg;
    ht_next     = ht_reg;
    ce_n_next   = ce_n_reg;
    oe_n_next   = oe_n_reg;
    we_n_next   = we_n_reg;
    doe_n_next  = doe_n_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    unique case (state_reg)
      strobe_timing_pkg::ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          // Chip select and address on the rising edge
          ce_n_next  = 1'b0;
          addr_next  = req_addr_i;
          wr_next    = req_write_i;
          wdata_next = req_wdata_i;
          cnt_next   = req_write_i ? write_setup_cycles : read_setup_cycles;
          pw_next    = req_write_i ? write_pulse_cycles : read_pulse_cycles;
          ht_next    = write_hold_cycles;
          state_next = strobe_timing_pkg::ST_SETUP;
        end
      end
      strobe_timing_pkg::ST_SETUP: begin
        // Strobe on the falling edge after setup periods plus high phase
        if (fall_en) begin
          if (cnt_reg == '0) begin
            oe_n_next   = wr_reg;
            we_n_next   = ~wr_reg;
            doe_n_next  = ~wr_reg;
            cnt_next    = pw_reg;
            state_next  = strobe_timing_pkg::ST_PULSE;
          end else begin
            cnt_next = cnt_reg - `FIELD_W'(1);
          end
        end
      end
      strobe_timing_pkg::ST_PULSE: begin
        // Strobe lasts pulse periods plus one low phase, ends on a rising edge
        if (rise_en) begin
          if (cnt_reg == '0) begin
            oe_n_next = 1'b1;
            we_n_next = 1'b1;
            if (!wr_reg) begin
              // Sample read data as the enable releases
              rdata_next  = mem_data_i;
              rvalid_next = 1'b1;
            end
            if (!wr_reg || ht_reg == '0) begin
              // Chip select ends on the same edge as the strobe
              ce_n_next  = 1'b1;
              doe_n_next = 1'b1;
              state_next = strobe_timing_pkg::ST_TAIL;
            end else begin
              cnt_next   = ht_reg - `FIELD_W'(1);
              state_next = strobe_timing_pkg::ST_HOLD;
            end
          end else begin
            cnt_next = cnt_reg - `FIELD_W'(1);
          end
        end
      end
      strobe_timing_pkg::ST_HOLD: begin
        // Write: data and chip select kept hold periods past strobe
        // Only writes with a nonzero hold come here
        if (rise_en) begin
          if (cnt_reg == '0) begin
            ce_n_next  = 1'b1;
            doe_n_next = 1'b1;
            state_next = strobe_timing_pkg::ST_TAIL;
          end else begin
            cnt_next = cnt_reg - `FIELD_W'(1);
          end
        end
      end
      strobe_timing_pkg::ST_TAIL: begin
        // One idle period between accesses so chip select is seen high
        if (fall_en) begin
          state_next = strobe_timing_pkg::ST_IDLE;
        end
      end
      default: state_next = strobe_timing_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg  <= strobe_timing_pkg::ST_IDLE;
      cnt_reg    <= '0;
      wr_reg     <= 1'b0;
      pw_reg     <= '0;
      ht_reg     <= '0;
      ce_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      doe_n_reg  <= 1'b1;
      addr_reg   <= '0;
      wdata_reg  <= 8'h00;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      wr_reg     <= wr_next;
      pw_reg     <= pw_next;
      ht_reg     <= ht_next;
      ce_n_reg   <= ce_n_next;
      oe_n_reg   <= oe_n_next;
      we_n_reg   <= we_n_next;
      doe_n_reg  <= doe_n_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign bus_clk_o       = bclk_reg;
  assign mem_ce_n_o      = ce_n_reg;
  assign mem_oe_n_o      = oe_n_reg;
  assign mem_we_n_o      = we_n_reg;
  assign mem_addr_o      = addr_reg;
  assign mem_data_o      = wdata_reg;
  assign mem_data_oe_n_o = doe_n_reg;
  assign rd_data_o       = rdata_reg;
  assign rd_valid_o      = rvalid_reg;

  // Helper: system cycles chip select has been low in the current access
  logic [11:0] ce_cnt;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ce_cnt <= '0;
    end else begin
      ce_cnt <= mem_ce_n_o ? 12'h000 : ce_cnt + 12'h001;
    end
  end

  a_read_ce_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ($rose(mem_ce_n_o) && !wr_reg) |->
      ($past(ce_cnt) + 12'h001 == 12'(({9'h000, read_setup_cycles} + {9'h000, read_pulse_cycles} + 12'h001) * BUS_DIV * 2)))
    else $error("read chip select width wrong");

  a_write_ce_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ($rose(mem_ce_n_o) && wr_reg) |->
      ($past(ce_cnt) + 12'h001 ==
       12'(({9'h000, write_setup_cycles} + {9'h000, write_pulse_cycles} + {9'h000, write_hold_cycles} + 12'h001) * BUS_DIV * 2)))
    else $error("write chip select width wrong");

  a_oe_after_ce: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(mem_oe_n_o) |-> ce_cnt == 12'((2 * {9'h000, read_setup_cycles} + 12'h001) * BUS_DIV))
    else $error("output enable setup wrong");

  a_we_after_ce: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(mem_we_n_o) |-> ce_cnt == 12'((2 * {9'h000, write_setup_cycles} + 12'h001) * BUS_DIV))
    else $error("write strobe setup wrong");

  a_oe_before_ce: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !mem_oe_n_o |-> !mem_ce_n_o)
    else $error("chip select released before output enable");

  a_oe_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(mem_oe_n_o) |-> ce_cnt ==
      12'((2 * ({9'h000, read_setup_cycles} + {9'h000, read_pulse_cycles}) + 12'h002) * BUS_DIV))
    else $error("output enable width wrong");

  a_we_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(mem_we_n_o) |-> ce_cnt ==
      12'((2 * ({9'h000, write_setup_cycles} + {9'h000, write_pulse_cycles}) + 12'h002) * BUS_DIV))
    else $error("write strobe width wrong");

  a_wdata_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!mem_we_n_o || !mem_data_oe_n_o) |-> (!mem_ce_n_o && $stable(mem_data_o)))
    else $error("write data not held");

  a_fabric_bypass: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    req_fabric_i |-> !req_ready_o)
    else $error("fabric access entered sequencer");

  a_ce_on_rise: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(mem_ce_n_o) |-> bus_clk_o)
    else $error("chip select not on rising bus clock");

  a_oe_on_fall: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(mem_oe_n_o) |-> !bus_clk_o)
    else $error("output enable not on falling bus clock");

  a_we_on_fall: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(mem_we_n_o) |-> !bus_clk_o)
    else $error("write strobe not on falling bus clock");

  a_rdata_pulse: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(mem_oe_n_o) |-> rd_valid_o)
    else $error("read data not captured at enable release");

endmodule : async_memory_strobe_timing

// [bench/async_memory_model.sv]
// Byte-wide asynchronous memory standing on the far side of the strobes
`timescale 1ns/1ps
module async_memory_model #(
  parameter int ACC_NS = 6
) (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        drive_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o
);
  logic [7:0] mem [256];
  logic [7:0] data_d;
  logic [7:0] addr_d;
  logic       ce_d;
  // Delayed copies give the part a hold time across the write strobe edge
  assign #1 data_d = drive_n_i ? ~data_i : data_i;
  assign #1 addr_d = addr_i[7:0];
  assign #1 ce_d   = ce_n_i;
  initial data_o = 8'h00;
  always @(posedge we_n_i) begin
    if (!ce_d) begin
      mem[addr_d] = data_d;
    end
  end
  // Released bus flips every time so a stale byte never looks valid
  always @(ce_n_i, oe_n_i, addr_i) begin
    if (!ce_n_i && !oe_n_i) begin
      data_o <= #(ACC_NS) mem[addr_i[7:0]];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : async_memory_model

// [bench/async_memory_strobe_timing_test.sv]
// Self-checking bench for the strobe sequencer against a memory model
`timescale 1ns/1ps
module async_memory_strobe_timing_test;
  localparam int DIV = 2;
  localparam int P   = 2 * DIV;
  localparam int H   = DIV;
  logic        sys_clk_i  = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic [7:0]  ctrl_low   = 8'h00;
  logic [7:0]  ctrl_high  = 8'h00;
  logic        req_valid  = 1'b0;
  logic        req_write  = 1'b0;
  logic        req_fabric = 1'b0;
  logic [15:0] req_addr   = 16'h0000;
  logic [7:0]  req_wdata  = 8'h00;
  logic        req_ready, rd_valid, bus_clk, ce_n, oe_n, we_n, data_oe_n;
  logic [15:0] mem_addr;
  logic [7:0]  rd_data, mem_din, mem_dout, rdd;
  int          err_total = 0;
  int          tests_run = 0;
  int          ce_f, ce_c, oe_f, oe_c, we_f, we_c, doe_f, doe_c, bad, rdv;

  always #2 sys_clk_i = ~sys_clk_i;

  async_memory_strobe_timing #(.ADDR_W(16), .BUS_DIV(DIV)) u_dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .strobe_ctrl_low_byte_i(ctrl_low),
    .strobe_ctrl_high_byte_i(ctrl_high), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_fabric_i(req_fabric), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .req_ready_o(req_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .bus_clk_o(bus_clk),
    .mem_ce_n_o(ce_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n), .mem_addr_o(mem_addr),
    .mem_data_i(mem_din), .mem_data_o(mem_dout), .mem_data_oe_n_o(data_oe_n));

  async_memory_model #(.ACC_NS(6)) u_mem (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .drive_n_i(data_oe_n),
    .addr_i(mem_addr), .data_i(mem_dout), .data_o(mem_din));

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // One access, then a fixed window long enough for the slowest field mix
  task access(input logic wr, input logic [2:0] su, input logic [2:0] pw,
              input logic [2:0] ht, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk_i);
    ctrl_low  <= wr ? {ht[1:0], pw, su} : 8'hff;
    ctrl_high <= wr ? {1'b0, 6'h3f, ht[2]} : {1'b0, pw, su, 1'b1};
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    chk(16'(req_ready), 16'h0001, "ready");
    @(posedge sys_clk_i);
    req_valid <= 1'b0;
    {ce_f, oe_f, we_f, doe_f} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1};
    {ce_c, oe_c, we_c, doe_c, bad, rdv} = '0;
    for (int n = 1; n < 100; n++) begin
      @(negedge sys_clk_i);
      if (ce_n === 1'b0) begin
        if (ce_f < 0) ce_f = n;
        if (ce_f == n) chk(mem_addr, a, "address");
        if (ce_f == n) chk(16'(bus_clk), 16'h0001, "bus clock at ce");
        ce_c++;
      end
      if (oe_n === 1'b0) begin
        if (oe_f < 0) oe_f = n;
        if (oe_f == n) chk(16'(bus_clk), 16'h0000, "bus clock at oe");
        oe_c++;
      end
      if (we_n === 1'b0) begin
        if (we_f < 0) we_f = n;
        if (we_f == n) chk(16'(bus_clk), 16'h0000, "bus clock at we");
        if (mem_dout !== d) bad++;
        we_c++;
      end
      if (data_oe_n === 1'b0) begin
        if (doe_f < 0) doe_f = n;
        doe_c++;
      end
      if (rd_valid === 1'b1) begin
        rdv++;
        rdd = rd_data;
      end
    end
    chk(16'(ce_f), 16'h0001, "ce start");
    if (wr) begin
      chk(16'(ce_c), 16'((su + pw + ht + 1) * P), "write ce width");
      chk(16'(we_f - ce_f), 16'(su * P + H), "we delay");
      chk(16'(we_c), 16'(pw * P + H), "we width");
      chk(16'(doe_f), 16'(we_f), "data drive start");
      chk(16'(doe_c), 16'(pw * P + H + ht * P), "data drive length");
      chk(16'(bad), 16'h0000, "write data");
      chk(16'(ce_f + ce_c - we_f - we_c), 16'(ht * P), "ce after we");
      chk(16'(oe_c + rdv), 16'h0000, "no read strobe");
    end else begin
      chk(16'(ce_c), 16'((su + pw + 1) * P), "read ce width");
      chk(16'(oe_f - ce_f), 16'(su * P + H), "oe delay");
      chk(16'(oe_c), 16'(pw * P + H), "oe width");
      chk(16'(oe_f + oe_c <= ce_f + ce_c), 16'h0001, "ce before oe");
      chk(16'(rdv), 16'h0001, "read pulse");
      chk({8'h00, rdd}, {8'h00, d}, "read data");
      chk(16'(we_c + doe_c), 16'h0000, "no write strobe");
    end
  endtask : access

  task sc_fabric;
    int hits;
    hits = 0;
    @(posedge sys_clk_i);
    req_fabric <= 1'b1;
    req_valid  <= 1'b1;
    repeat (40) begin
      @(negedge sys_clk_i);
      if (ce_n !== 1'b1 || req_ready !== 1'b0) hits++;
    end
    chk(16'(hits), 16'h0000, "fabric refused");
    @(posedge sys_clk_i);
    req_valid  <= 1'b0;
    req_fabric <= 1'b0;
  endtask : sc_fabric

  task sc_write_sweep;
    for (int v = 0; v < 8; v++) begin
      access(1'b1, 3'(v), 3'(7 - v), 3'(v), 16'h0a50 + 16'(v), 8'h5a ^ 8'(v * 37));
    end
  endtask : sc_write_sweep

  task sc_read_sweep;
    for (int v = 0; v < 8; v++) begin
      access(1'b0, 3'(7 - v), 3'(v), 3'(v), 16'h0a50 + 16'(v), 8'h5a ^ 8'(v * 37));
    end
  endtask : sc_read_sweep

  task sc_zero_wait;
    access(1'b0, 3'h0, 3'h2, 3'h0, 16'h0a52, 8'h5a ^ 8'(2 * 37));
  endtask : sc_zero_wait

  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    sc_fabric();
    sc_write_sweep();
    sc_read_sweep();
    sc_zero_wait();
    wrap_up();
  end

  // Seventeen accesses of about a hundred cycles each fit well inside this
  initial begin
    #(P * 4 * 5000);
    err_total++;
    wrap_up();
  end
endmodule : async_memory_strobe_timing_test
